// [verilog/cal_seq_pkg.sv]
package cal_seq_pkg;
   // ----------------------------------------------------------------
   // register map (word aligned byte offsets, all chosen for this block)
   // ----------------------------------------------------------------
   localparam logic [7:0] ctrl_offset = 8'h00;
   localparam logic [7:0] status_offset = 8'h04;
   localparam logic [7:0] vco_code_offset = 8'h08;
   localparam logic [7:0] edges_offset = 8'h0C;
   localparam logic [7:0] filter_offset = 8'h10;
   localparam logic [7:0] rssi_offset = 8'h14;
   localparam logic [7:0] iq_offset = 8'h18;
   // ----------------------------------------------------------------
   // control bit positions
   // ----------------------------------------------------------------
   localparam int ctrl_start_bit = 0;
   localparam int ctrl_cmp_power_bit = 1;
   localparam int ctrl_low_thr_sel_bit = 2;
   localparam int ctrl_stage_lsb = 4;
   // ----------------------------------------------------------------
   // comparator pair codes {high, low}
   // ----------------------------------------------------------------
   localparam logic [1:0] cmp_too_high = 2'h0;
   localparam logic [1:0] cmp_in_range = 2'h2;
   localparam logic [1:0] cmp_too_low = 2'h3;
   localparam logic [1:0] cmp_impossible = 2'h1;
   // ----------------------------------------------------------------
   // status codes reported to the controller
   // ----------------------------------------------------------------
   localparam logic [1:0] stat_idle = 2'h0;
   localparam logic [1:0] stat_busy = 2'h1;
   localparam logic [1:0] stat_ok = 2'h2;
   localparam logic [1:0] stat_fail = 2'h3;
   // ----------------------------------------------------------------
   // filter stages; first three are trans-impedance type
   // ----------------------------------------------------------------
   localparam int num_stages = 6;
   localparam logic [2:0] stage_ti_limit = 3'h3;
   // comparator settling after each capacitor step
   localparam int settle_ns = 1000;
   localparam int clk_ns = 50;
   localparam int settle_cycles = (settle_ns + clk_ns - 1) / clk_ns;
   // sweep state machine
   typedef enum logic [4:0] {
      st_idle = 5'b00001,
      st_step = 5'b00010,
      st_wait = 5'b00100,
      st_judge = 5'b01000,
      st_done = 5'b10000
   } sweep_state_t;
endpackage

// [verilog/code_register.sv]
`timescale 1ns/1ns
`default_nettype none
// one software writable code register with reset value
module code_register #(
   parameter int width = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [width-1:0] data_i,
   output logic [width-1:0] q_o
);
   // register holds the code steering one analog control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= '0;
      end else if (load_i) begin
         q_o <= data_i;
      end
   end
endmodule
`default_nettype wire

// [verilog/cal_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - high threshold fixed, low threshold selectable
// - comparator pair reports 10 ok 00 high 11 low
// - all stages share one resistor and one capacitor code
// - meter valid only for a single tone
module cal_sequencer
   import cal_seq_pkg::*;
#(
   parameter int code_width = 8,
   parameter int filt_width = 8,
   parameter int iq_width = 12,
   parameter int rssi_width = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // analog side
   input wire logic high_threshold_comparator_i,
   input wire logic low_threshold_comparator_i,
   input wire logic [rssi_width-1:0] rssi_i,
   output logic comparator_power_o,
   output logic low_threshold_select_o,
   output logic [code_width-1:0] vco_capacitor_code_o,
   output logic lock_o,
   output logic [cal_seq_pkg::num_stages-1:0] stage_enable_o,
   output logic [filt_width-1:0] filter_resistor_code_o,
   output logic [filt_width-1:0] filter_capacitor_code_o,
   output logic [iq_width-1:0] tx_inphase_word_o,
   output logic [iq_width-1:0] tx_quadrature_word_o
);
   import cal_seq_pkg::*;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic req; // valid access waiting for answer
   logic wr_ctrl, wr_vco, wr_filt; // write strobes
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr_ctrl = req & we_i & sel_i[0] & (adr_i == ctrl_offset);
   assign wr_vco = req & we_i & sel_i[0] & (adr_i == vco_code_offset);
   assign wr_filt = req & we_i & (&sel_i[1:0]) & (adr_i == filter_offset);

   // one cycle answer, dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   logic cmp_power_reg; // comparator power enable
   logic low_sel_reg; // 0 picks the higher low threshold
   logic [2:0] stage_reg; // filter stage selected for tuning
   logic start_pulse; // begin a capacitor sweep
   assign start_pulse = wr_ctrl & dat_i[ctrl_start_bit];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmp_power_reg <= 1'b0;
         low_sel_reg <= 1'b0;
         stage_reg <= '0;
      end else if (wr_ctrl) begin
         cmp_power_reg <= dat_i[ctrl_cmp_power_bit];
         low_sel_reg <= dat_i[ctrl_low_thr_sel_bit];
         stage_reg <= dat_i[ctrl_stage_lsb +: 3];
      end
   end
   assign comparator_power_o = cmp_power_reg;
   assign low_threshold_select_o = low_sel_reg;

   // only the stage under tuning is enabled
   always_comb begin
      stage_enable_o = '0;
      if (32'(stage_reg) < num_stages) begin
         stage_enable_o[stage_reg] = 1'b1;
      end
   end

   // comparator pair as {high, low}; meaningful only when powered
   logic [1:0] cmp_pair;
   assign cmp_pair = {high_threshold_comparator_i, low_threshold_comparator_i};
   assign lock_o = cmp_power_reg & (cmp_pair == cmp_in_range);

   // ----------------------------------------------------------------
   // filter codes: one resistor and one capacitor code, shared by all stages
   // ----------------------------------------------------------------
   code_register #(.width(filt_width)) res_code (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(wr_filt),
      .data_i(dat_i[filt_width-1:0]),
      .q_o(filter_resistor_code_o)
   );
   code_register #(.width(filt_width)) cap_code (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(wr_filt),
      .data_i(dat_i[8 +: filt_width]),
      .q_o(filter_capacitor_code_o)
   );

   // test words: reset to +max on I and -max on Q
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_inphase_word_o <= {1'b0, {(iq_width-1){1'b1}}};
         tx_quadrature_word_o <= {1'b1, {(iq_width-1){1'b0}}};
      end else if (req & we_i & (&sel_i) & (adr_i == iq_offset)) begin
         tx_inphase_word_o <= dat_i[iq_width-1:0];
         tx_quadrature_word_o <= dat_i[16 +: iq_width];
      end
   end

   // ----------------------------------------------------------------
   // capacitor sweep engine
   // ----------------------------------------------------------------
   sweep_state_t state_reg;
   logic [code_width-1:0] code_reg; // code under test
   logic [code_width-1:0] lower_edge_code, upper_edge_code;
   logic seen_lower, seen_upper; // edges found so far
   logic [1:0] prev_pair; // pair seen at the previous code
   logic [1:0] status_reg;
   logic [15:0] settle_cnt;
   logic last_code;
   logic [code_width:0] edge_sum;
   assign last_code = &code_reg;
   assign edge_sum = {1'b0, lower_edge_code} + {1'b0, upper_edge_code};

   // sweep sequencing and status; software may also write the code directly while in st_idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= st_idle;
         code_reg <= '0;
         lower_edge_code <= '0;
         upper_edge_code <= '0;
         seen_lower <= 1'b0;
         seen_upper <= 1'b0;
         prev_pair <= cmp_too_high;
         status_reg <= stat_idle;
         settle_cnt <= '0;
      end else begin
         case (state_reg)
            st_idle: begin
               // the same write powers the pair, so look at the written bit, not the old one
               if (start_pulse & dat_i[ctrl_cmp_power_bit]) begin
                  code_reg <= '0;
                  seen_lower <= 1'b0;
                  seen_upper <= 1'b0;
                  prev_pair <= cmp_impossible; // no earlier code yet
                  status_reg <= stat_busy;
                  state_reg <= st_step;
               end else if (start_pulse) begin
                  status_reg <= stat_fail; // comparators unpowered
               end else if (wr_vco) begin
                  code_reg <= dat_i[code_width-1:0];
               end
            end
            st_step: begin
               settle_cnt <= 16'(settle_cycles);
               state_reg <= st_wait;
            end
            st_wait: begin
               // comparators need time to follow a new code
               if (settle_cnt == 16'h0001) begin
                  state_reg <= st_judge;
               end
               settle_cnt <= settle_cnt - 16'h0001;
            end
            st_judge: begin
               prev_pair <= cmp_pair;
               if (prev_pair == cmp_too_high && cmp_pair == cmp_in_range && !seen_lower) begin
                  lower_edge_code <= code_reg;
                  seen_lower <= 1'b1;
               end
               if (prev_pair == cmp_in_range && cmp_pair == cmp_too_low && seen_lower) begin
                  upper_edge_code <= code_reg;
                  seen_upper <= 1'b1;
                  state_reg <= st_done;
               end else if (last_code) begin
                  status_reg <= stat_fail;
                  state_reg <= st_idle;
               end else begin
                  code_reg <= code_reg + 1'b1;
                  state_reg <= st_step;
               end
            end
            st_done: begin
               code_reg <= edge_sum[code_width:1];
               status_reg <= stat_ok;
               state_reg <= st_idle;
            end
            default: begin
               state_reg <= st_idle;
            end
         endcase
      end
   end
   assign vco_capacitor_code_o = code_reg;

   // ----------------------------------------------------------------
   // read mux, registered; unmapped addresses read zero
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (req & ~we_i) begin
         case (adr_i)
            ctrl_offset: dat_o <= 32'({stage_reg, 1'b0, low_sel_reg, cmp_power_reg, 1'b0});
            status_offset: dat_o <= 32'({seen_upper, seen_lower, lock_o, cmp_pair, status_reg});
            vco_code_offset: dat_o <= 32'(code_reg);
            edges_offset: dat_o <= {8'h00, 8'(upper_edge_code), 8'h00, 8'(lower_edge_code)};
            filter_offset: dat_o <= {16'h0000, 8'(filter_capacitor_code_o), 8'(filter_resistor_code_o)};
            rssi_offset: dat_o <= 32'(rssi_i);
            iq_offset: dat_o <= {4'h0, 12'(tx_quadrature_word_o), 4'h0, 12'(tx_inphase_word_o)};
            default: dat_o <= '0;
         endcase
      end
   end
endmodule
`default_nettype wire

// [bench/cal_seq_checker.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// port checks for the sequencer
// ------------------------------------------------------------
module cal_seq_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic ack_o,
   input wire logic high_threshold_comparator_i,
   input wire logic low_threshold_comparator_i,
   input wire logic comparator_power_o,
   input wire logic low_threshold_select_o,
   input wire logic lock_o,
   input wire logic [5:0] stage_enable_o,
   input wire logic [11:0] tx_inphase_word_o,
   input wire logic [11:0] tx_quadrature_word_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_lock; lock_o == (comparator_power_o && high_threshold_comparator_i && !low_threshold_comparator_i);
   endproperty
   a_lock: assert property (p_lock) else $error("lock not tied to in-range pair");
   property p_stage; $onehot0(stage_enable_o); endproperty
   a_stage: assert property (p_stage) else $error("more than one stage enabled");
   property p_words; $past(rst_i) |-> tx_inphase_word_o == 12'h7FF && tx_quadrature_word_o == 12'h800; endproperty
   a_words: assert property (p_words) else $error("test words wrong after reset");
   property p_power; !$stable(comparator_power_o) |-> $past(cyc_i && stb_i && we_i); endproperty
   a_power: assert property (p_power) else $error("power changed without write");
   property p_thr; !$stable(low_threshold_select_o) |-> $past(cyc_i && stb_i && we_i); endproperty
   a_thr: assert property (p_thr) else $error("threshold changed without write");
endmodule
bind cal_sequencer cal_seq_checker i_cal_seq_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .high_threshold_comparator_i(high_threshold_comparator_i),
   .low_threshold_comparator_i(low_threshold_comparator_i), .comparator_power_o(comparator_power_o),
   .low_threshold_select_o(low_threshold_select_o), .lock_o(lock_o), .stage_enable_o(stage_enable_o),
   .tx_inphase_word_o(tx_inphase_word_o), .tx_quadrature_word_o(tx_quadrature_word_o));
`default_nettype wire

// [bench/analog_model.sv]
`timescale 1ns/1ns
`default_nettype none
// tuning comparators and meter; voltage falls as capacitor code rises
module analog_model (
   input wire logic clk_i,
   input wire logic power_i,
   input wire logic low_sel_i,
   input wire logic [7:0] code_i,
   input wire logic [8:0] lower_i,
   input wire logic [8:0] upper_i,
   output logic high_o,
   output logic low_o,
   output logic [15:0] rssi_o
);
   logic [1:0] pair_reg = 2'h0; // unpowered swing inverts the last pair: 00/11, or 10/01 after an in-range pair
   logic [15:0] level_reg = 16'h0;
   assign {high_o, low_o} = pair_reg;
   assign rssi_o = level_reg;
   always @(posedge clk_i) begin
      if (!power_i) begin // unpowered pair means nothing, so it toggles
         pair_reg <= ~pair_reg;
      end else if ({2'b0, code_i} < {1'b0, lower_i}) begin // tuning voltage too high
         pair_reg <= 2'h0;
      end else if ({2'b0, code_i} < {1'b0, upper_i} + {9'h0, low_sel_i}) begin // in range
         pair_reg <= 2'h2;
      end else begin // lower threshold moves the upper edge one code up
         pair_reg <= 2'h3;
      end
      level_reg <= {8'h5A, code_i}; // single tone level
   end
endmodule
`default_nettype wire

// [bench/test_cal_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// bench: reset values, stage and filter codes, sweeps
// ------------------------------------------------------------
module test_cal_sequencer;
   import cal_seq_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0, dat_o, rd, d;
   logic ack_o, hi, lo, pwr, lsel, lock_o;
   logic [15:0] rssi;
   logic [7:0] vco, l, u, res, cap;
   logic [11:0] tx_inphase_word, tx_quadrature_word;
   logic [3:0] sel_i = 4'hF;
   logic [5:0] stg;
   logic [8:0] lower = 9'h010, upper = 9'h020;
   logic [63:0] exp_q[$], note;
   int err_count = 0, n_compared = 0, i;
   initial forever #25 clk_i = ~clk_i;
   cal_sequencer i_cal_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .high_threshold_comparator_i(hi), .low_threshold_comparator_i(lo), .rssi_i(rssi),
      .comparator_power_o(pwr), .low_threshold_select_o(lsel), .vco_capacitor_code_o(vco), .lock_o(lock_o),
      .stage_enable_o(stg), .filter_resistor_code_o(res), .filter_capacitor_code_o(cap),
      .tx_inphase_word_o(tx_inphase_word), .tx_quadrature_word_o(tx_quadrature_word));
   analog_model i_analog_model (.clk_i(clk_i), .power_i(pwr), .low_sel_i(lsel), .code_i(vco),
      .lower_i(lower), .upper_i(upper), .high_o(hi), .low_o(lo), .rssi_o(rssi));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // classic single cycle; held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      if (n >= 50) begin // a silent slave ends the run
         err_count++;
         results();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      exp_q.push_back({m, v});
      bus(1'b0, a, 32'h0);
   endtask
   // start a sweep and poll status until it leaves busy
   task automatic sweep(input logic [31:0] ctrl, input logic [1:0] want);
      int n;
      bus(1'b1, ctrl_offset, ctrl);
      n = 0;
      do begin
         bus(1'b0, status_offset, 32'h0);
         n++;
      end while (rd[1:0] === stat_busy && n < 4000);
      if (n >= 4000) begin // a sweep that never ends
         err_count++;
         results();
      end
      check({30'h0, rd[1:0]}, {30'h0, want});
   endtask
   // read results arrive on ack; oldest note is compared
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         check(dat_o & note[63:32], note[31:0]);
      end
   end
   initial begin
      i = $urandom(56282);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_exp(ctrl_offset, 32'hFFFFFFFF, 32'h0);
      rd_exp(iq_offset, 32'hFFFFFFFF, 32'h0800_07FF);
      rd_exp(8'h1C, 32'hFFFFFFFF, 32'h0);
      // vco tuning runs before filter work: two good sweeps, both thresholds, then one with no upper edge
      for (i = 0; i < 3; i++) begin
         lower = 9'($urandom_range(5, 100));
         upper = (i == 2) ? 9'h1FF : 9'($urandom_range(120, 250));
         l = lower[7:0];
         u = upper[7:0] + 8'(i % 2);
         sweep({29'h0, 1'(i % 2), 2'b11}, (i == 2) ? stat_fail : stat_ok);
         check({31'h0, lsel}, 32'(i % 2));
         check({31'h0, pwr}, 32'h1);
         if (i < 2) begin
            rd_exp(status_offset, 32'h7F, 32'h7A);
            rd_exp(edges_offset, 32'h00FF00FF, {8'h0, u, 8'h0, l});
            rd_exp(vco_code_offset, 32'hFF, 32'((9'(l) + 9'(u)) >> 1));
            check({24'h0, vco}, 32'((9'(l) + 9'(u)) >> 1));
            rd_exp(rssi_offset, 32'hFFFF, {16'h0, 8'h5A, 8'((9'(l) + 9'(u)) >> 1)});
            check({31'h0, lock_o}, 32'h1);
         end else begin
            rd_exp(status_offset, 32'h7F, 32'h3B);
            rd_exp(vco_code_offset, 32'hFF, 32'hFF);
         end
      end
      for (i = 0; i < 8; i++) begin // every stage code, two past the last
         d = $urandom;
         bus(1'b1, ctrl_offset, 32'(i) << 4);
         check({26'h0, stg}, (i < 6) ? (32'h1 << i) : 32'h0);
         bus(1'b1, filter_offset, {16'h0, d[15:0]});
         check({16'h0, cap, res}, {16'h0, d[15:0]});
         rd_exp(filter_offset, 32'h0000FFFF, {16'h0, d[15:0]});
      end
      // test words: a write on two lanes only must be refused
      d = $urandom;
      sel_i <= 4'h3;
      bus(1'b1, iq_offset, d);
      sel_i <= 4'hF;
      rd_exp(iq_offset, 32'h0FFF0FFF, 32'h0800_07FF);
      bus(1'b1, iq_offset, d);
      rd_exp(iq_offset, 32'h0FFF0FFF, d & 32'h0FFF0FFF);
      check({20'h0, tx_inphase_word}, {20'h0, d[11:0]});
      check({20'h0, tx_quadrature_word}, {20'h0, d[27:16]});
      sweep(32'h1, stat_fail);
      bus(1'b1, vco_code_offset, 32'h77);
      rd_exp(vco_code_offset, 32'hFF, 32'h77);
      results();
   end
endmodule
`default_nettype wire
